// file: shared/iplc_pkg.sv
// package: constants, tables and carrier types of the priority-level block
`default_nettype none
package iplc_pkg;
	localparam int ADDR_W   = 4;
	localparam int DATA_W   = 16;
	localparam int NUM_PRIO = 5;
	localparam int LEVEL_W  = 4;
	localparam int NUM_SRC  = 39;
	localparam int NUM_EVT  = 3;
	localparam int VEC_W    = 8;
	localparam int OFFS_W   = 10;
	localparam int NUM_PIN  = 8;

	// register word indices on the plain register port
	localparam logic [3:0] ADDR_PINS_LOW  = 4'h0;
	localparam logic [3:0] ADDR_PINS_HIGH = 4'h1;
	localparam logic [3:0] ADDR_DMA_TMR   = 4'h2;
	localparam logic [3:0] ADDR_TMR_SER   = 4'h3;
	localparam logic [3:0] ADDR_MISC      = 4'h4;
	localparam logic [3:0] ADDR_EVT_STAT  = 4'h5;
	localparam logic [3:0] ADDR_EVT_CLR   = 4'h6;
	localparam logic [3:0] ADDR_EVT_EN    = 4'h7;

	localparam logic [15:0] PRIO_RESET = 16'h0000;
	localparam logic [15:0] MISC_WMASK = 16'hFFF0; // low field reserved
	localparam logic [2:0]  EVT_RESET  = 3'h0;
	localparam logic [15:0] READ_ZERO  = 16'h0000;

	// event bit positions
	localparam int EVT_FORWARD  = 0;
	localparam int EVT_RESV_WR  = 1;
	localparam int EVT_UNMAPPED = 2;

	// source index layout, ascending vector order
	localparam int SRC_PIN    = 0;
	localparam int SRC_DMA    = 8;
	localparam int SRC_TIMER  = 12;
	localparam int SRC_SERIAL = 27;
	localparam int SRC_PARITY = 35;
	localparam int SRC_ADC    = 36;
	localparam int SRC_WDOG   = 37;
	localparam int SRC_REFR   = 38;

	localparam logic [7:0] VEC_PIN0    = 8'h40; // 64
	localparam logic [7:0] VEC_DMA0    = 8'h48; // 72
	localparam logic [7:0] VEC_DMA1    = 8'h4A; // 74
	localparam logic [7:0] VEC_RESV_LO = 8'h6E; // 110
	localparam logic [7:0] VEC_RESV_HI = 8'h6F; // 111
	localparam logic [7:0] VEC_LAST    = 8'h71; // 113

	// vector number of each source
	localparam logic [7:0] SRC_VEC [0:NUM_SRC-1] = '{
		8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47,
		8'h48, 8'h4A, 8'h4C, 8'h4E,
		8'h50, 8'h51, 8'h52, 8'h54, 8'h55, 8'h56, 8'h58, 8'h59, 8'h5A,
		8'h5C, 8'h5D, 8'h5E, 8'h60, 8'h61, 8'h62,
		8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6A, 8'h6B,
		8'h6C, 8'h6D, 8'h70, 8'h71
	};

	// level field (register*4 + slot, slot 0 = bits 15-12) of each source
	localparam logic [4:0] SRC_FIELD [0:NUM_SRC-1] = '{
		5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
		5'h08, 5'h08, 5'h09, 5'h09,
		5'h0A, 5'h0A, 5'h0A, 5'h0B, 5'h0B, 5'h0B, 5'h0C, 5'h0C, 5'h0C,
		5'h0D, 5'h0D, 5'h0D, 5'h0E, 5'h0E, 5'h0E,
		5'h0F, 5'h0F, 5'h0F, 5'h0F, 5'h10, 5'h10, 5'h10, 5'h10,
		5'h11, 5'h11, 5'h12, 5'h12
	};

	typedef logic [NUM_PRIO-1:0][DATA_W-1:0] iplc_prio_t;

	// on-chip peripheral request levels, all active high
	typedef struct packed {
		logic [3:0] dma_transfer_end;
		logic [4:0] compare_a_match;
		logic [4:0] compare_b_match;
		logic [4:0] timer_overflow;
		logic [1:0] receive_error;
		logic [1:0] receive_full;
		logic [1:0] transmit_empty;
		logic [1:0] transmit_end;
		logic       parity_error;
		logic       adc_unit_event;
		logic       watchdog_unit_event;
		logic       refresh_compare_match;
	} iplc_periph_req_t;

	// register port request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} iplc_bus_req_t;

	typedef struct packed {
		iplc_prio_t        prio;
		logic [DATA_W-1:0] rdata;
	} iplc_regs_state_t;

	typedef struct packed {
		logic [NUM_PIN-1:0]  pin_meta;
		logic [NUM_PIN-1:0]  pin_sync;
		logic                req;
		logic [LEVEL_W-1:0]  level;
		logic [VEC_W-1:0]    vector;
		logic [OFFS_W-1:0]   offset;
		logic [NUM_EVT-1:0]  status;
		logic [NUM_EVT-1:0]  enable;
		logic                irq;
	} iplc_state_t;
endpackage
`default_nettype wire

// file: logic/iplc_regs.sv
// priority register file with registered read port
`timescale 1ns/1ns
`default_nettype none
module iplc_regs (
	input  wire logic                     clk_in,
	input  wire logic                     srst_in,
	input  wire iplc_pkg::iplc_bus_req_t  bus_in,
	input  wire logic [2:0]               evt_status_in,
	input  wire logic [2:0]               evt_enable_in,
	output iplc_pkg::iplc_prio_t          prio_out,
	output logic [15:0]                   rdata_out
);
	iplc_pkg::iplc_regs_state_t s_q;
	iplc_pkg::iplc_regs_state_t s_d;

	// write decode and read mux; standby has no input here, so contents survive it
	always_comb begin
		s_d = s_q;
		s_d.rdata = iplc_pkg::READ_ZERO;
		if (bus_in.wr && bus_in.addr <= iplc_pkg::ADDR_MISC) begin
			s_d.prio[bus_in.addr[2:0]] = bus_in.wdata;
			if (bus_in.addr == iplc_pkg::ADDR_MISC) begin
				s_d.prio[4] = bus_in.wdata & iplc_pkg::MISC_WMASK;
			end
		end
		if (bus_in.rd) begin
			case (bus_in.addr)
				iplc_pkg::ADDR_PINS_LOW,
				iplc_pkg::ADDR_PINS_HIGH,
				iplc_pkg::ADDR_DMA_TMR,
				iplc_pkg::ADDR_TMR_SER,
				iplc_pkg::ADDR_MISC: begin
					s_d.rdata = s_q.prio[bus_in.addr[2:0]];
				end
				iplc_pkg::ADDR_EVT_STAT: s_d.rdata = {13'h0000, evt_status_in};
				iplc_pkg::ADDR_EVT_EN:   s_d.rdata = {13'h0000, evt_enable_in};
				default:                 s_d.rdata = iplc_pkg::READ_ZERO;
			endcase
		end
		if (srst_in) begin
			s_d.prio  = {iplc_pkg::NUM_PRIO{iplc_pkg::PRIO_RESET}};
			s_d.rdata = iplc_pkg::READ_ZERO;
		end
	end

	always_ff @(posedge clk_in) begin
		s_q <= s_d;
	end

	assign prio_out  = s_q.prio;
	assign rdata_out = s_q.rdata;

	a_reset_clears: assert property (@(posedge clk_in) srst_in |=> (s_q.prio == '0))
		else $error("priority registers not cleared by reset");
	a_reserved_zero: assert property (@(posedge clk_in) disable iff (srst_in)
		bus_in.wr && bus_in.addr == iplc_pkg::ADDR_MISC |=> s_q.prio[4][3:0] == 4'h0)
		else $error("reserved field took a nonzero value");
endmodule
`default_nettype wire

// file: logic/iplc_top.sv
// priority-level arbiter: level registers, request selection, cpu request
`timescale 1ns/1ns
`default_nettype none
module iplc_top (
	input  wire logic                       CLOCK_IN,
	input  wire logic                       SRST_IN,
	input  wire logic                       STANDBY_IN,
	input  wire logic [7:0]                 IRQ_PIN_N_IN,
	input  wire iplc_pkg::iplc_periph_req_t PERIPH_REQ_IN,
	input  wire logic [3:0]                 CPU_MASK_LEVEL_IN,
	input  wire logic [3:0]                 ADDR_IN,
	input  wire logic [15:0]                WDATA_IN,
	input  wire logic                       WR_IN,
	input  wire logic                       RD_IN,
	output logic [15:0]                     RDATA_OUT,
	output logic                            CPU_REQ_OUT,
	output logic [3:0]                      CPU_LEVEL_OUT,
	output logic [7:0]                      CPU_VECTOR_OUT,
	output logic [9:0]                      VECTOR_OFFSET_OUT,
	output logic                            IRQ_OUT
);
	iplc_pkg::iplc_state_t      s_q;
	iplc_pkg::iplc_state_t      s_d;
	iplc_pkg::iplc_prio_t       prio;
	iplc_pkg::iplc_bus_req_t    bus;
	logic [iplc_pkg::NUM_SRC-1:0] req_vec;
	logic                       win_found;
	logic [3:0]                 win_level;
	logic [7:0]                 win_vector;
	logic                       fwd;
	logic [2:0]                 evt;
	logic                       clr_wr;

	// level of one field: register field/4, slot field%4 from the top down
	function automatic logic [3:0] field_level(
		input iplc_pkg::iplc_prio_t p,
		input logic [4:0]           field
	);
		logic [15:0] word;
		logic [1:0]  slot;
		word = p[field[4:2]];
		slot = field[1:0];
		case (slot)
			2'h0:    field_level = word[15:12];
			2'h1:    field_level = word[11:8];
			2'h2:    field_level = word[7:4];
			default: field_level = word[3:0];
		endcase
	endfunction

	// flatten the request lines into ascending vector order
	function automatic logic [iplc_pkg::NUM_SRC-1:0] pack_requests(
		input logic [7:0]                 pins,
		input iplc_pkg::iplc_periph_req_t pr
	);
		logic [iplc_pkg::NUM_SRC-1:0] r;
		r = '0;
		for (int i = 0; i < iplc_pkg::NUM_PIN; i++) begin
			r[iplc_pkg::SRC_PIN + i] = pins[i];
		end
		for (int c = 0; c < 4; c++) begin
			r[iplc_pkg::SRC_DMA + c] = pr.dma_transfer_end[c];
		end
		// within-module rank 2..0 falls on ascending vectors, so the tie order covers it
		for (int t = 0; t < 5; t++) begin
			r[iplc_pkg::SRC_TIMER + 3*t]     = pr.compare_a_match[t];
			r[iplc_pkg::SRC_TIMER + 3*t + 1] = pr.compare_b_match[t];
			r[iplc_pkg::SRC_TIMER + 3*t + 2] = pr.timer_overflow[t];
		end
		for (int p = 0; p < 2; p++) begin
			r[iplc_pkg::SRC_SERIAL + 4*p]     = pr.receive_error[p];
			r[iplc_pkg::SRC_SERIAL + 4*p + 1] = pr.receive_full[p];
			r[iplc_pkg::SRC_SERIAL + 4*p + 2] = pr.transmit_empty[p];
			r[iplc_pkg::SRC_SERIAL + 4*p + 3] = pr.transmit_end[p];
		end
		// parity and refresh lines are driven by the bus controller
		r[iplc_pkg::SRC_PARITY] = pr.parity_error;
		r[iplc_pkg::SRC_ADC]    = pr.adc_unit_event;
		r[iplc_pkg::SRC_WDOG]   = pr.watchdog_unit_event;
		r[iplc_pkg::SRC_REFR]   = pr.refresh_compare_match;
		pack_requests = r;
	endfunction

	// one driver for the whole request word: wr, rd, addr, wdata from the top down
	assign bus = {WR_IN, RD_IN, ADDR_IN, WDATA_IN};

	// register file keeps contents through standby; only reset clears them
	iplc_regs u_regs (
		.clk_in        (CLOCK_IN),
		.srst_in       (SRST_IN),
		.bus_in        (bus),
		.evt_status_in (s_q.status),
		.evt_enable_in (s_q.enable),
		.prio_out      (prio),
		.rdata_out     (RDATA_OUT)
	);

	// pins are active low levels, read only after the two-stage synchroniser
	assign req_vec = pack_requests(~s_q.pin_sync, PERIPH_REQ_IN);

	// scan high vector to low with >=, so the lowest vector wins a tie
	always_comb begin
		logic [3:0] lvl;
		lvl        = 4'h0;
		win_found  = 1'b0;
		win_level  = 4'h0;
		win_vector = 8'h00;
		for (int i = iplc_pkg::NUM_SRC - 1; i >= 0; i--) begin
			lvl = field_level(prio, iplc_pkg::SRC_FIELD[i]);
			if (req_vec[i] && (!win_found || lvl >= win_level)) begin
				win_found  = 1'b1;
				win_level  = lvl;
				win_vector = iplc_pkg::SRC_VEC[i];
			end
		end
	end

	// strict compare: a level-0 source can never pass, which is how reset masks
	assign fwd = win_found && (win_level > CPU_MASK_LEVEL_IN);

	// event sources for the status register
	assign clr_wr = WR_IN && ADDR_IN == iplc_pkg::ADDR_EVT_CLR;
	always_comb begin
		evt = 3'h0;
		evt[iplc_pkg::EVT_FORWARD]  = fwd && !s_q.req;
		evt[iplc_pkg::EVT_RESV_WR]  = WR_IN && ADDR_IN == iplc_pkg::ADDR_MISC
			&& WDATA_IN[3:0] != 4'h0;
		evt[iplc_pkg::EVT_UNMAPPED] = (WR_IN || RD_IN) && ADDR_IN > iplc_pkg::ADDR_EVT_EN;
	end

	// next state: synchroniser, cpu request outputs, event registers
	always_comb begin
		s_d = s_q;
		s_d.pin_meta = IRQ_PIN_N_IN;
		s_d.pin_sync = s_q.pin_meta;
		s_d.req      = fwd;
		s_d.level    = fwd ? win_level : 4'h0;
		s_d.vector   = fwd ? win_vector : 8'h00;
		s_d.offset   = fwd ? {win_vector, 2'b00} : 10'h000;
		// a set in the cycle of its clear wins over the clear
		s_d.status = (s_q.status & ~(clr_wr ? WDATA_IN[2:0] : 3'h0)) | evt;
		if (WR_IN && ADDR_IN == iplc_pkg::ADDR_EVT_EN) begin
			s_d.enable = WDATA_IN[2:0];
		end
		s_d.irq = |(s_d.status & s_d.enable);
		if (SRST_IN) begin
			s_d.pin_meta = 8'hFF;
			s_d.pin_sync = 8'hFF;
			s_d.req      = 1'b0;
			s_d.level    = 4'h0;
			s_d.vector   = 8'h00;
			s_d.offset   = 10'h000;
			s_d.status   = iplc_pkg::EVT_RESET;
			s_d.enable   = iplc_pkg::EVT_RESET;
			s_d.irq      = 1'b0;
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		s_q <= s_d;
	end

	assign CPU_REQ_OUT       = s_q.req;
	assign CPU_LEVEL_OUT     = s_q.level;
	assign CPU_VECTOR_OUT    = s_q.vector;
	assign VECTOR_OFFSET_OUT = s_q.offset;
	assign IRQ_OUT           = s_q.irq;

	// checks on the arbiter and register behaviour
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (SRST_IN);

	sequence seq_prio_write;
		WR_IN && ADDR_IN <= iplc_pkg::ADDR_TMR_SER;
	endsequence
	sequence seq_quiet_standby;
		STANDBY_IN && !WR_IN;
	endsequence
	sequence seq_enable_pending;
		WR_IN && ADDR_IN == iplc_pkg::ADDR_EVT_EN && (WDATA_IN[2:0] & s_q.status) != 3'h0;
	endsequence

	a_write_lands: assert property (seq_prio_write |=> prio[$past(ADDR_IN[2:0])] == $past(WDATA_IN))
		else $error("priority write not stored");
	a_standby_hold: assert property (seq_quiet_standby |=> $stable(prio))
		else $error("priority registers changed in standby");
	a_mask_gate: assert property (CPU_REQ_OUT |-> CPU_LEVEL_OUT > $past(CPU_MASK_LEVEL_IN))
		else $error("request forwarded at or below mask level");
	a_offset_four: assert property (VECTOR_OFFSET_OUT == {CPU_VECTOR_OUT, 2'b00})
		else $error("vector offset not four times vector");
	a_pin_level: assert property (CPU_REQ_OUT && CPU_VECTOR_OUT == iplc_pkg::VEC_PIN0
		|-> CPU_LEVEL_OUT == $past(prio[0][15:12]))
		else $error("pin 0 level not from top field");
	a_dma_share: assert property (CPU_REQ_OUT && (CPU_VECTOR_OUT == iplc_pkg::VEC_DMA0
		|| CPU_VECTOR_OUT == iplc_pkg::VEC_DMA1) |-> CPU_LEVEL_OUT == $past(prio[2][15:12]))
		else $error("shared dma field level mismatch");
	a_vector_legal: assert property (CPU_REQ_OUT |-> CPU_VECTOR_OUT >= iplc_pkg::VEC_PIN0
		&& CPU_VECTOR_OUT <= iplc_pkg::VEC_LAST && CPU_VECTOR_OUT != iplc_pkg::VEC_RESV_LO
		&& CPU_VECTOR_OUT != iplc_pkg::VEC_RESV_HI)
		else $error("reserved vector presented");
	a_pin_forward: assert property ((!s_q.pin_sync[0] && prio[0][15:12] == 4'hF
		&& CPU_MASK_LEVEL_IN != 4'hF) |=> CPU_REQ_OUT && CPU_VECTOR_OUT == iplc_pkg::VEC_PIN0)
		else $error("top-level pin 0 request not forwarded");
	a_irq_follows: assert property (seq_enable_pending |=> IRQ_OUT ##1 IRQ_OUT || $past(clr_wr))
		else $error("enabled pending event did not raise interrupt");
endmodule
`default_nettype wire

// file: tb/iplc_cpu_model.sv
// cpu core stand-in: holds the mask level and takes accepted requests
`timescale 1ns/1ns
`default_nettype none
module iplc_cpu_model #(
	parameter logic [3:0] MASK_RESET = 4'h0
) (
	input  wire logic       clk_in,
	input  wire logic       srst_in,
	input  wire logic       req_in,
	input  wire logic [3:0] level_in,
	input  wire logic       accept_en_in,
	input  wire logic       load_in,
	input  wire logic [3:0] load_val_in,
	output logic      [3:0] mask_level_out
);
	// an accepted level becomes the new mask, so equal levels stop requesting
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			mask_level_out <= MASK_RESET;
		end else if (load_in) begin
			mask_level_out <= load_val_in;
		end else if (accept_en_in && req_in) begin
			mask_level_out <= level_in;
		end
	end
endmodule
`default_nettype wire

// file: tb/iplc_top_bench.sv
// self-checking bench of the priority-level arbiter
`timescale 1ns/1ns
`default_nettype none
module iplc_top_bench;
	logic clk, srst, stby, wr_s, rd_s, acc, ld;
	logic [7:0] pins_n;
	logic [30:0] preq;
	logic [3:0] addr, ldv, mask, clvl;
	logic [15:0] wdata, rdata;
	logic creq, irq;
	logic [7:0] cvec;
	logic [9:0] coff;
	int n_fail, cmp_count;

	iplc_top u_dut (.CLOCK_IN(clk), .SRST_IN(srst), .STANDBY_IN(stby), .IRQ_PIN_N_IN(pins_n),
		.PERIPH_REQ_IN(iplc_pkg::iplc_periph_req_t'(preq)), .CPU_MASK_LEVEL_IN(mask),
		.ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata),
		.CPU_REQ_OUT(creq), .CPU_LEVEL_OUT(clvl), .CPU_VECTOR_OUT(cvec),
		.VECTOR_OFFSET_OUT(coff), .IRQ_OUT(irq));
	iplc_cpu_model u_cpu (.clk_in(clk), .srst_in(srst), .req_in(creq), .level_in(clvl),
		.accept_en_in(acc), .load_in(ld), .load_val_in(ldv), .mask_level_out(mask));

	// free-running 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// single-cycle strobes, never both; read data stands only the next cycle
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr_s <= 1'b1; addr <= a; wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		rd_s <= 1'b1; addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask

	task automatic chk_cpu(input logic r, input logic [3:0] l, input logic [7:0] v);
		chk("cpu_req", 16'(r), 16'(creq));
		chk("cpu_level", 16'(l), 16'(clvl));
		chk("cpu_vector", 16'(v), 16'(cvec));
		chk("vector_offset", 16'({v, 2'b00}), 16'(coff));
	endtask

	task automatic set_mask(input logic [3:0] v);
		@(posedge clk);
		ld <= 1'b1; ldv <= v;
		@(posedge clk);
		ld <= 1'b0;
	endtask

	// program one register, raise one request, expect its level and vector
	task automatic t_case(input logic [3:0] a, input logic [15:0] v, input logic [30:0] b,
			input logic [7:0] p, input logic [3:0] l, input logic [7:0] vec);
		wr(a, v);
		@(posedge clk);
		preq <= b; pins_n <= p;
		repeat (3) @(posedge clk);
		#1 chk_cpu(1'b1, l, vec);
		@(posedge clk);
		preq <= '0; pins_n <= 8'hFF;
		wr(a, 16'h0000);
	endtask

	task automatic s_reset();
		for (int i = 0; i < 5; i++) rd(4'(i), 16'h0000);
		rd(iplc_pkg::ADDR_EVT_EN, 16'h0000);
		chk_cpu(1'b0, 4'h0, 8'h00);
	endtask

	task automatic s_regs();
		logic [15:0] pat [0:4];
		pat = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0, 16'h4320};
		for (int i = 0; i < 5; i++) wr(4'(i), pat[i]);
		for (int i = 0; i < 5; i++) rd(4'(i), pat[i]);
		wr(iplc_pkg::ADDR_MISC, 16'h4325);
		rd(iplc_pkg::ADDR_MISC, 16'h4320);
		rd(iplc_pkg::ADDR_EVT_STAT, 16'h0002);
		rd(4'h9, 16'h0000);
		rd(iplc_pkg::ADDR_EVT_STAT, 16'h0006);
		wr(iplc_pkg::ADDR_EVT_CLR, 16'h0007);
		rd(iplc_pkg::ADDR_EVT_STAT, 16'h0000);
		for (int i = 0; i < 5; i++) wr(4'(i), 16'h0000);
	endtask

	// struct bit positions: dma 30:27, cmp a 26:22, cmp b 21:17, ovf 16:12, serial 11:4
	task automatic s_map();
		t_case(4'h2, 16'h0050, 31'(1) << 22, 8'hFF, 4'h5, 8'd80);
		t_case(4'h2, 16'h0A00, 31'(1) << 30, 8'hFF, 4'hA, 8'd78);
		t_case(4'h2, 16'hA000, 31'(1) << 28, 8'hFF, 4'hA, 8'd74);
		t_case(4'h3, 16'h0C00, 31'(1) << 15, 8'hFF, 4'hC, 8'd94);
		t_case(4'h3, 16'h000F, 31'(1) << 4, 8'hFF, 4'hF, 8'd103);
		t_case(4'h4, 16'h3000, 31'(1) << 9, 8'hFF, 4'h3, 8'd105);
		t_case(4'h4, 16'h0700, 31'(1) << 2, 8'hFF, 4'h7, 8'd109);
		t_case(4'h4, 16'h0700, 31'(1) << 3, 8'hFF, 4'h7, 8'd108);
		t_case(4'h4, 16'h0090, 31'(1) << 1, 8'hFF, 4'h9, 8'd112);
		t_case(4'h4, 16'h0090, 31'(1) << 0, 8'hFF, 4'h9, 8'd113);
		t_case(4'h1, 16'h0600, '0, 8'hDF, 4'h6, 8'd69);
		t_case(4'h0, 16'h1000, '0, 8'hFE, 4'h1, 8'd64);
		t_case(4'h0, 16'hF000, '0, 8'hFE, 4'hF, 8'd64);
	endtask

	// equal level stays refused, one below the level is forwarded
	task automatic s_mask();
		wr(4'h2, 16'h0050);
		set_mask(4'h5);
		@(posedge clk);
		preq <= 31'(1) << 22;
		repeat (2) @(posedge clk);
		#1 chk_cpu(1'b0, 4'h0, 8'h00);
		set_mask(4'h4);
		@(posedge clk);
		#1 chk_cpu(1'b1, 4'h5, 8'd80);
		set_mask(4'h0);
		@(posedge clk);
		preq <= '0;
	endtask

	task automatic s_ties();
		wr(4'h2, 16'h0055);
		@(posedge clk);
		preq <= (31'(1) << 17) | (31'(1) << 12) | (31'(1) << 23);
		repeat (2) @(posedge clk);
		#1 chk_cpu(1'b1, 4'h5, 8'd81);
		wr(4'h2, 16'h0056);
		@(posedge clk);
		#1 chk_cpu(1'b1, 4'h6, 8'd84);
		wr(4'h2, 16'h0000);
		@(posedge clk);
		preq <= '0;
	endtask

	// accepted request raises the mask, the sticky event keeps the line up
	task automatic s_accept();
		int n;
		wr(iplc_pkg::ADDR_EVT_CLR, 16'h0007);
		wr(iplc_pkg::ADDR_EVT_EN, 16'h0001);
		wr(4'h2, 16'h0050);
		@(posedge clk);
		acc <= 1'b1; preq <= 31'(1) << 22;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!(mask === 4'h5) && n < 8);
		if (n >= 8) begin
			n_fail++;
			tally_and_finish();
		end
		repeat (2) @(posedge clk);
		#1 chk_cpu(1'b0, 4'h0, 8'h00);
		chk("irq", 16'h0001, 16'(irq));
		@(posedge clk);
		acc <= 1'b0; preq <= '0;
		wr(iplc_pkg::ADDR_EVT_CLR, 16'h0001);
		set_mask(4'h0);
		#1 chk("irq", 16'h0000, 16'(irq));
		wr(iplc_pkg::ADDR_EVT_EN, 16'h0000);
		rd(4'hC, 16'h0000);
		chk("irq", 16'h0000, 16'(irq));
		wr(iplc_pkg::ADDR_EVT_EN, 16'h0004);
		@(posedge clk);
		#1 chk("irq", 16'h0001, 16'(irq));
		wr(iplc_pkg::ADDR_EVT_CLR, 16'h0007);
		wr(4'h2, 16'h0000);
	endtask

	task automatic s_standby();
		wr(4'h3, 16'hA5A0);
		@(posedge clk);
		stby <= 1'b1;
		repeat (4) @(posedge clk);
		stby <= 1'b0;
		rd(4'h3, 16'hA5A0);
	endtask

	// mid-run reset clears written levels and drops a live request
	task automatic s_rerst();
		wr(4'h2, 16'h0050);
		@(posedge clk);
		preq <= 31'(1) << 22;
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		preq <= '0;
		#1 chk_cpu(1'b0, 4'h0, 8'h00);
		for (int i = 0; i < 5; i++) rd(4'(i), 16'h0000);
	endtask

	// all inputs defined at time zero, reset held twelve cycles
	initial begin
		n_fail = 0; cmp_count = 0;
		srst = 1'b1; stby = 1'b0; wr_s = 1'b0; rd_s = 1'b0; acc = 1'b0; ld = 1'b0;
		pins_n = 8'hFF; preq = '0; addr = 4'h0; wdata = 16'h0000; ldv = 4'h0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		s_reset();
		s_regs();
		s_map();
		s_mask();
		s_ties();
		s_accept();
		s_standby();
		s_rerst();
		tally_and_finish();
	end
endmodule
`default_nettype wire
